/* logic/sdc_pkg.sv */
// constants shared by the converter result control block
package sdc_pkg;
	// register offsets
	localparam logic [7:0] OFS_EN_CLR = 8'h05;
	localparam logic [7:0] OFS_EN_SET = 8'h06;
	localparam logic [7:0] OFS_FLAGS = 8'h07;
	localparam logic [7:0] OFS_SEQ_STATE = 8'h08;
	localparam logic [7:0] OFS_INPUT_SEL = 8'h09;
	localparam logic [7:0] OFS_RUN_CTRL = 8'h0a;
	localparam logic [7:0] OFS_WIN_CTRL = 8'h0b;
	localparam logic [7:0] OFS_WIN_LOWER = 8'h0c;
	localparam logic [7:0] OFS_WIN_UPPER = 8'h10;
	localparam logic [7:0] OFS_OFFSET = 8'h14;
	localparam logic [7:0] OFS_GAIN = 8'h18;
	localparam logic [7:0] OFS_SHIFT = 8'h1a;
	localparam logic [7:0] OFS_SW_TRIG = 8'h1c;
	localparam logic [7:0] OFS_CROSS_BUSY = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h24;
	localparam logic [7:0] OFS_SEQ_EN = 8'h28;
	// flag and enable, sequence busy, software start and gain field bit positions
	localparam int FLG_READY = 0;
	localparam int FLG_OVERRUN = 1;
	localparam int FLG_WINDOW = 2;
	localparam int SEQ_BUSY_POS = 7;
	localparam int SW_START_POS = 1;
	localparam int GAIN_POS = 14;
	// crossing busy bit positions
	localparam int CB_RUN = 2;
	localparam int CB_INPUT = 3;
	localparam int CB_WIN = 4;
	localparam int CB_LOWER = 5;
	localparam int CB_UPPER = 6;
	localparam int CB_OFFSET = 7;
	localparam int CB_SHIFT = 9;
	localparam int CB_TRIG = 10;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [1:0] RST_GAIN = 2'h0;
	// cycles a write takes to cross into the converter side
	localparam int SYNC_CYCLES = 3;
	typedef enum logic [2:0] {
		SDC_WIN_OFF = 3'h0,
		SDC_WIN_ABOVE = 3'h1,
		SDC_WIN_BELOW = 3'h2,
		SDC_WIN_INSIDE = 3'h3,
		SDC_WIN_OUTSIDE = 3'h4
	} sdc_win_t;
	typedef enum logic {
		SDC_IDLE = 1'b0,
		SDC_CONV = 1'b1
	} sdc_state_t;
endpackage

/* logic/sdc_result_control.sv */
// converter result control: flags, sequencing, window monitor, calibration
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module sdc_result_control #(
	parameter int SYNC_LEN = sdc_pkg::SYNC_CYCLES,
	parameter logic [1:0] GAIN_FIELD = sdc_pkg::RST_GAIN
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic writeGuard,
	input wire logic convTrigger,
	input wire logic convDone,
	input wire logic [23:0] convRaw,
	output logic convStart,
	output logic [3:0] inputPairCode,
	output logic irqReq
);
	import sdc_pkg::*;

	if (SYNC_LEN < 1 || SYNC_LEN > 15) begin : g_bad_sync
		$error("SYNC_LEN must be 1 to 15");
	end

	// ****************************************
	// helpers
	// ****************************************
	// lowest enabled input at or above a start index, with found bit
	function automatic logic [2:0] pickPair(input logic [2:0] en, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 2; i >= 0; i--) begin
			if (en[i] && 3'(i) >= from) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] ofs);
		return regAddr == ofs;
	endfunction

	// ****************************************
	// register bus decode
	// ****************************************
	logic wrOk;
	logic rdResult;
	logic flagClrWr;
	assign wrOk = regWr && !writeGuard;
	assign rdResult = regRd && hit(OFS_RESULT);
	assign flagClrWr = regWr && hit(OFS_FLAGS);

	logic wrInput, wrRun, wrWin, wrLower, wrUpper, wrOffset, wrShift, wrTrig;
	assign wrInput = wrOk && hit(OFS_INPUT_SEL);
	assign wrRun = wrOk && hit(OFS_RUN_CTRL);
	assign wrWin = wrOk && hit(OFS_WIN_CTRL);
	assign wrLower = wrOk && hit(OFS_WIN_LOWER);
	assign wrUpper = wrOk && hit(OFS_WIN_UPPER);
	assign wrOffset = wrOk && hit(OFS_OFFSET);
	assign wrShift = wrOk && hit(OFS_SHIFT);
	assign wrTrig = wrOk && hit(OFS_SW_TRIG) && regWdata[SW_START_POS];

	// ****************************************
	// software-facing copies
	// ****************************************
	logic [2:0] irqEn_reg;
	logic [3:0] inputSel_reg;
	logic continuous_convert_reg;
	logic [2:0] window_condition_reg;
	logic [23:0] lower_reg, upper_reg, offset_reg;
	logic [7:0] shift_reg;
	logic [2:0] sequence_input_enable_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqEn_reg <= RST_BYTE[2:0];
		end else if (wrOk && hit(OFS_EN_CLR)) begin
			irqEn_reg <= irqEn_reg & ~regWdata[2:0];
		end else if (wrOk && hit(OFS_EN_SET)) begin
			irqEn_reg <= irqEn_reg | regWdata[2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			inputSel_reg <= RST_BYTE[3:0];
			continuous_convert_reg <= 1'b0;
			window_condition_reg <= RST_BYTE[2:0];
			lower_reg <= RST_WORD;
			upper_reg <= RST_WORD;
			offset_reg <= RST_WORD;
			shift_reg <= RST_BYTE;
			sequence_input_enable_reg <= RST_BYTE[2:0];
		end else begin
			if (wrInput) inputSel_reg <= regWdata[3:0];
			if (wrRun) continuous_convert_reg <= regWdata[0];
			if (wrWin) window_condition_reg <= regWdata[2:0];
			if (wrLower) lower_reg <= regWdata[23:0];
			if (wrUpper) upper_reg <= regWdata[23:0];
			if (wrOffset) offset_reg <= regWdata[23:0];
			if (wrShift) shift_reg <= regWdata[7:0];
			if (wrOk && hit(OFS_SEQ_EN)) sequence_input_enable_reg <= regWdata[2:0];
		end
	end

	// ****************************************
	// crossing into the converter side
	// ****************************************
	// one shared countdown; any new write to a crossed register restarts it
	logic [10:0] cbSet;
	logic [10:0] crossBusy_reg;
	logic [3:0] syncCnt_reg, quietCnt_reg;
	logic syncWr;
	logic syncDone;
	always_comb begin
		cbSet = 11'h000;
		cbSet[CB_RUN] = wrRun;
		cbSet[CB_INPUT] = wrInput;
		cbSet[CB_WIN] = wrWin;
		cbSet[CB_LOWER] = wrLower;
		cbSet[CB_UPPER] = wrUpper;
		cbSet[CB_OFFSET] = wrOffset;
		cbSet[CB_SHIFT] = wrShift;
		cbSet[CB_TRIG] = wrTrig;
	end
	assign syncWr = |cbSet;
	assign syncDone = syncCnt_reg == 4'h1 && !syncWr;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncCnt_reg <= 4'h0;
			crossBusy_reg <= 11'h000;
			quietCnt_reg <= 4'h0;
		end else begin
			if (syncWr) quietCnt_reg <= 4'h0;
			else if (quietCnt_reg != 4'hf) quietCnt_reg <= quietCnt_reg + 4'h1;
			if (syncWr) begin
				syncCnt_reg <= 4'(SYNC_LEN);
			end else if (syncCnt_reg != 4'h0) begin
				syncCnt_reg <= syncCnt_reg - 4'h1;
			end
			crossBusy_reg <= cbSet | (syncDone ? 11'h000 : crossBusy_reg);
		end
	end

	// converter-side working copies
	logic [3:0] actInput_reg;
	logic actFree_reg;
	logic [2:0] actWin_reg;
	logic [23:0] actLower_reg, actUpper_reg, actOffset_reg;
	logic [7:0] actShift_reg;
	logic swStart;
	assign swStart = syncDone && crossBusy_reg[CB_TRIG];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			actInput_reg <= RST_BYTE[3:0];
			actFree_reg <= 1'b0;
			actWin_reg <= RST_BYTE[2:0];
			actLower_reg <= RST_WORD;
			actUpper_reg <= RST_WORD;
			actOffset_reg <= RST_WORD;
			actShift_reg <= RST_BYTE;
		end else if (syncDone) begin
			actInput_reg <= inputSel_reg;
			actFree_reg <= continuous_convert_reg;
			actWin_reg <= window_condition_reg;
			actLower_reg <= lower_reg;
			actUpper_reg <= upper_reg;
			actOffset_reg <= offset_reg;
			actShift_reg <= shift_reg;
		end
	end

	// ****************************************
	// conversion sequencing
	// ****************************************
	sdc_state_t state_reg, state_next;
	logic sequence_busy_reg, sequence_busy_next;
	logic [3:0] seqPtr_reg;
	logic [2:0] firstPick, nextPick;
	logic anySeq, launch, done, hasNext;
	logic [3:0] launchPair;

	assign anySeq = |sequence_input_enable_reg;
	assign firstPick = pickPair(sequence_input_enable_reg, 3'h0);
	assign nextPick = pickPair(sequence_input_enable_reg, 3'(inputPairCode[1:0]) + 3'h1);
	assign done = convDone && state_reg == SDC_CONV;
	assign hasNext = sequence_busy_reg && nextPick[2];

	always_comb begin
		state_next = state_reg;
		sequence_busy_next = sequence_busy_reg;
		launch = 1'b0;
		launchPair = actInput_reg;
		unique case (state_reg)
			SDC_IDLE: begin
				if (convTrigger || swStart) begin
					launch = 1'b1;
				end
			end
			SDC_CONV: begin
				if (done) begin
					state_next = SDC_IDLE;
					sequence_busy_next = 1'b0;
					if (hasNext) begin
						launch = 1'b1;
						sequence_busy_next = 1'b1;
						launchPair = {2'h0, nextPick[1:0]};
					end else if (actFree_reg) begin
						launch = 1'b1;
					end
				end
			end
		endcase
		if (launch && !hasNext) begin
			sequence_busy_next = anySeq;
			if (anySeq) launchPair = {2'h0, firstPick[1:0]};
		end
		if (launch) state_next = SDC_CONV;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= SDC_IDLE;
			sequence_busy_reg <= 1'b0;
			convStart <= 1'b0;
			inputPairCode <= RST_BYTE[3:0];
			seqPtr_reg <= RST_BYTE[3:0];
		end else begin
			state_reg <= state_next;
			sequence_busy_reg <= sequence_busy_next;
			convStart <= launch;
			if (launch) inputPairCode <= launchPair;
			if (done && sequence_busy_reg) seqPtr_reg <= inputPairCode;
		end
	end

	// ****************************************
	// calibration and result
	// ****************************************
	logic signed [25:0] sumVal;
	logic signed [28:0] prodVal;
	logic signed [28:0] shiftVal;
	logic [2:0] gainMul;
	// field zero would null every result, so gain runs one to four
	assign gainMul = {1'b0, GAIN_FIELD} + 3'h1;
	assign sumVal = 26'(signed'(convRaw)) + 26'(signed'(actOffset_reg));
	assign prodVal = 29'(sumVal) * signed'({1'b0, gainMul});
	assign shiftVal = prodVal >>> actShift_reg;

	logic [23:0] result_reg;
	logic unread_reg, fresh_reg;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			result_reg <= RST_WORD;
			unread_reg <= 1'b0;
			fresh_reg <= 1'b0;
		end else begin
			if (done) result_reg <= shiftVal[23:0];
			unread_reg <= done || (unread_reg && !rdResult);
			fresh_reg <= done;
		end
	end

	// ****************************************
	// window monitor
	// ****************************************
	logic signed [23:0] resS, lowS, upS;
	logic aboveLow, belowUp, winMatch;
	assign resS = signed'(result_reg);
	assign lowS = signed'(actLower_reg);
	assign upS = signed'(actUpper_reg);
	assign aboveLow = resS > lowS;
	assign belowUp = resS < upS;
	always_comb begin
		unique case (actWin_reg)
			SDC_WIN_ABOVE: winMatch = aboveLow;
			SDC_WIN_BELOW: winMatch = belowUp;
			SDC_WIN_INSIDE: winMatch = aboveLow && belowUp;
			SDC_WIN_OUTSIDE: winMatch = resS > upS || resS < lowS;
			default: winMatch = 1'b0;
		endcase
	end

	// ****************************************
	// flags and interrupt
	// ****************************************
	logic [2:0] flags_reg, flagSet, flagClr;
	assign flagSet = {fresh_reg && winMatch, done && unread_reg, done};
	assign flagClr = (flagClrWr ? regWdata[2:0] : 3'h0) | {rdResult, 1'b0, rdResult};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			flags_reg <= RST_BYTE[2:0];
			irqReq <= 1'b0;
		end else begin
			flags_reg <= flagSet | (flags_reg & ~flagClr);
			irqReq <= |(flags_reg & irqEn_reg);
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [31:0] rdNext;
	always_comb begin
		rdNext = 32'h00000000;
		unique case (regAddr)
			OFS_EN_CLR, OFS_EN_SET: rdNext[2:0] = irqEn_reg;
			OFS_FLAGS: rdNext[2:0] = flags_reg;
			OFS_SEQ_STATE: rdNext[7:0] = {sequence_busy_reg, 3'h0, seqPtr_reg};
			OFS_INPUT_SEL: rdNext[3:0] = inputSel_reg;
			OFS_RUN_CTRL: rdNext[0] = continuous_convert_reg;
			OFS_WIN_CTRL: rdNext[2:0] = window_condition_reg;
			OFS_WIN_LOWER: rdNext[23:0] = lower_reg;
			OFS_WIN_UPPER: rdNext[23:0] = upper_reg;
			OFS_OFFSET: rdNext[23:0] = offset_reg;
			OFS_GAIN: rdNext[15:0] = {GAIN_FIELD, 14'h0000};
			OFS_SHIFT: rdNext[7:0] = shift_reg;
			OFS_CROSS_BUSY: rdNext[10:0] = crossBusy_reg;
			OFS_RESULT: rdNext[23:0] = result_reg;
			OFS_SEQ_EN: rdNext[2:0] = sequence_input_enable_reg;
			default: rdNext = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			regRdata <= 32'h00000000;
		end else begin
			regRdata <= regRd ? rdNext : 32'h00000000;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_irq_follows: assert property (@(posedge core_clk) disable iff (srst)
		irqReq == |($past(flags_reg) & $past(irqEn_reg)))
		else $error("interrupt not tied to enabled flags");

	chk_enable_clear: assert property (@(posedge core_clk) disable iff (srst)
		wrOk && regAddr == OFS_EN_CLR |=> (irqEn_reg & $past(regWdata[2:0])) == 3'h0)
		else $error("enable clear failed");

	chk_enable_set: assert property (@(posedge core_clk) disable iff (srst)
		wrOk && regAddr == OFS_EN_SET
		|=> (irqEn_reg & $past(regWdata[2:0])) == $past(regWdata[2:0]))
		else $error("enable set failed");

	chk_ready_set: assert property (@(posedge core_clk) disable iff (srst)
		done |=> flags_reg[FLG_READY] && result_reg == $past(shiftVal[23:0]))
		else $error("result ready not set with result");

	chk_window_late: assert property (@(posedge core_clk) disable iff (srst)
		done ##1 winMatch |=> flags_reg[FLG_WINDOW])
		else $error("window flag missed");

	chk_overrun_sticky: assert property (@(posedge core_clk) disable iff (srst)
		flags_reg[FLG_OVERRUN] && !(flagClrWr && regWdata[FLG_OVERRUN]) |=> flags_reg[FLG_OVERRUN])
		else $error("overrun lost without write one");

	chk_read_clears: assert property (@(posedge core_clk) disable iff (srst)
		rdResult && !done && !(fresh_reg && winMatch) |=> flags_reg[FLG_READY] == 1'b0 && !flags_reg[FLG_WINDOW])
		else $error("result read did not clear flags");

	chk_cross_busy: assert property (@(posedge core_clk) disable iff (srst)
		quietCnt_reg >= 4'(SYNC_LEN) |-> crossBusy_reg == 11'h000 && actLower_reg == lower_reg)
		else $error("crossing did not finish");

	chk_single_stop: assert property (@(posedge core_clk) disable iff (srst)
		done && !actFree_reg && !hasNext |=> !convStart && state_reg == SDC_IDLE && !sequence_busy_reg)
		else $error("single mode restarted");

	chk_free_restart: assert property (@(posedge core_clk) disable iff (srst)
		done && actFree_reg |=> convStart)
		else $error("continuous mode did not restart");

	chk_result_hold: assert property (@(posedge core_clk) disable iff (srst)
		!done |=> $stable(result_reg))
		else $error("result changed without conversion");
endmodule

`default_nettype wire

/* testbench/sdc_conv_model.sv */
// converter model: answers each start after a set delay with a raw code
`timescale 1ns/100ps
`default_nettype none
module sdc_conv_model (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic convStart,
	input wire logic [3:0] inputPairCode,
	input wire logic [3:0] dly,
	input wire logic [23:0] rawIn,
	output logic convDone,
	output logic [23:0] convRaw,
	output logic [3:0] lastPair
);
	int cnt;
	// raw code only valid with done, scrambled otherwise
	always @(posedge core_clk) begin
		convDone <= 1'b0;
		convRaw <= ~convRaw;
		if (srst) begin
			cnt = 0;
			convRaw <= 24'h000000;
			lastPair <= 4'h0;
		end else if (convStart) begin
			cnt = dly + 1;
			lastPair <= inputPairCode;
		end else if (cnt > 0) begin
			cnt = cnt - 1;
			if (cnt == 0) begin
				convDone <= 1'b1;
				convRaw <= rawIn;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/sdc_result_control_tb.sv */
// self-checking bench for the converter result control block
`timescale 1ns/100ps
`default_nettype none
module sdc_result_control_tb;
	import sdc_pkg::*;
	// ************
	// environment
	// ************
	localparam int SL = 8;
	localparam logic [1:0] GF = 2'h1;
	logic core_clk, srst, regWr, regRd, writeGuard, convTrigger, convDone, convStart, irqReq;
	logic [7:0] regAddr, sh;
	logic [31:0] regWdata, regRdata, rv;
	logic [23:0] convRaw, rawIn, lo, hi, off, r, x;
	logic [3:0] inputPairCode, dly, lastPair, sel;
	logic [3:0] pq[$];
	logic e;
	logic [7:0] ofs[14] = '{OFS_EN_CLR, OFS_EN_SET, OFS_FLAGS, OFS_SEQ_STATE, OFS_INPUT_SEL,
		OFS_RUN_CTRL, OFS_WIN_CTRL, OFS_WIN_LOWER, OFS_WIN_UPPER, OFS_OFFSET, OFS_GAIN,
		OFS_SHIFT, OFS_CROSS_BUSY, 8'h30};
	int numErrors = 0;
	int nCompared = 0;
	int cyc = 0;
	int starts = 0;
	sdc_result_control #(.SYNC_LEN(SL), .GAIN_FIELD(GF)) i_dut (.core_clk(core_clk),
		.srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .writeGuard(writeGuard), .convTrigger(convTrigger),
		.convDone(convDone), .convRaw(convRaw), .convStart(convStart),
		.inputPairCode(inputPairCode), .irqReq(irqReq));
	sdc_conv_model i_conv (.core_clk(core_clk), .srst(srst), .convStart(convStart),
		.inputPairCode(inputPairCode), .dly(dly), .rawIn(rawIn), .convDone(convDone),
		.convRaw(convRaw), .lastPair(lastPair));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// counted off the falling edge to stay clear of the driver
	always @(negedge core_clk) begin
		cyc++;
		if (convStart === 1'b1) begin
			starts++;
			pq.push_back(inputPairCode);
		end
		if (cyc == 20000) begin
			numErrors++;
			endSim();
		end
	end
	// ************
	// helpers
	// ************
	task automatic endSim();
		$display("compared %0d errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		cy(1);
		regWr <= 1'b0;
		cy(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		cy(1);
		regRd <= 1'b0;
		#1 d = regRdata;
		cy(1);
	endtask
	task automatic ckr(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	task automatic conv(input logic [23:0] v);
		int k;
		rawIn <= v;
		convTrigger <= 1'b1;
		cy(1);
		convTrigger <= 1'b0;
		for (k = 0; k < 40 && convDone !== 1'b1; k++) cy(1);
		chk("done", k < 40, 1);
		cy(3);
	endtask
	function automatic logic [23:0] calib(input logic [23:0] v);
		logic signed [47:0] t;
		t = $signed(v) + $signed(off);
		t = t * (48'sd1 + $signed({1'b0, GF}));
		t = t >>> sh;
		return t[23:0];
	endfunction
	function automatic logic wm(input logic [2:0] m, input logic [23:0] v);
		case (m)
			3'h1: return $signed(v) > $signed(lo);
			3'h2: return $signed(v) < $signed(hi);
			3'h3: return $signed(v) > $signed(lo) && $signed(v) < $signed(hi);
			3'h4: return $signed(v) > $signed(hi) || $signed(v) < $signed(lo);
			default: return 1'b0;
		endcase
	endfunction
	// ************
	// sequence
	// ************
	initial begin
		srst = 1'b1;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		writeGuard = 1'b0;
		convTrigger = 1'b0;
		rawIn = 24'h0;
		dly = 4'h0;
		void'($urandom(18866));
		cy(3);
		srst <= 1'b0;
		cy(1);
		foreach (ofs[i]) ckr(ofs[i], ofs[i] == OFS_GAIN ? 32'(GF) << GAIN_POS : 32'h0);
		wr(OFS_EN_SET, 32'h7);
		ckr(OFS_EN_CLR, 32'h7);
		wr(OFS_EN_CLR, 32'h2);
		ckr(OFS_EN_SET, 32'h5);
		wr(OFS_EN_SET, 32'h0);
		wr(OFS_EN_CLR, 32'h0);
		ckr(OFS_EN_CLR, 32'h5);
		off = 24'(int'($urandom_range(0, 2047)) - 1024);
		sh = 8'($urandom_range(0, 3));
		sel = 4'($urandom_range(0, 2));
		lo = 24'hfff000;
		hi = 24'h001000;
		wr(OFS_RUN_CTRL, 32'h0);
		wr(OFS_INPUT_SEL, {28'h0, sel});
		wr(OFS_WIN_CTRL, 32'h0);
		wr(OFS_WIN_LOWER, {8'h0, lo});
		wr(OFS_WIN_UPPER, {8'h0, hi});
		wr(OFS_OFFSET, {8'h0, off});
		wr(OFS_SHIFT, {24'h0, sh});
		ckr(OFS_CROSS_BUSY, 32'h2fc);
		cy(SL + 4);
		ckr(OFS_CROSS_BUSY, 32'h0);
		ckr(OFS_WIN_LOWER, {8'h0, lo});
		ckr(OFS_WIN_UPPER, {8'h0, hi});
		ckr(OFS_OFFSET, {8'h0, off});
		ckr(OFS_SHIFT, {24'h0, sh});
		ckr(OFS_INPUT_SEL, {28'h0, sel});
		writeGuard <= 1'b1;
		wr(OFS_WIN_LOWER, 32'h0);
		ckr(OFS_CROSS_BUSY, 32'h0);
		ckr(OFS_WIN_LOWER, {8'h0, lo});
		writeGuard <= 1'b0;
		wr(OFS_GAIN, 32'hc000);
		ckr(OFS_GAIN, 32'(GF) << GAIN_POS);
		wr(OFS_EN_CLR, 32'h7);
		wr(OFS_EN_SET, 32'h4);
		for (int m = 0; m < 5; m++) begin
			wr(OFS_WIN_CTRL, 32'(m));
			cy(SL + 2);
			for (int n = 0; n < 4; n++) begin
				r = 24'(int'($urandom_range(0, 16383)) - 8192);
				dly <= 4'($urandom_range(0, 5));
				conv(r);
				x = calib(r);
				e = wm(3'(m), x);
				chk("pair", lastPair, sel);
				chk("irq", irqReq, e);
				ckr(OFS_FLAGS, {29'h0, e, 2'b01});
				ckr(OFS_RESULT, {8'h0, x});
				ckr(OFS_FLAGS, 32'h0);
			end
		end
		wr(OFS_WIN_CTRL, 32'h0);
		wr(OFS_EN_SET, 32'h3);
		cy(SL + 2);
		conv(24'h000100);
		conv(24'hffff00);
		chk("irq", irqReq, 1'b1);
		ckr(OFS_FLAGS, 32'h3);
		ckr(OFS_RESULT, {8'h0, calib(24'hffff00)});
		ckr(OFS_FLAGS, 32'h2);
		wr(OFS_FLAGS, 32'h0);
		ckr(OFS_FLAGS, 32'h2);
		wr(OFS_FLAGS, 32'h2);
		ckr(OFS_FLAGS, 32'h0);
		conv(24'h000010);
		wr(OFS_FLAGS, 32'h1);
		ckr(OFS_FLAGS, 32'h0);
		starts = 0;
		conv(24'h000020);
		cy(10);
		chk("single", starts, 1);
		wr(OFS_RUN_CTRL, 32'h1);
		cy(SL + 2);
		starts = 0;
		conv(24'h000030);
		cy(30);
		chk("free", starts > 3, 1);
		wr(OFS_RUN_CTRL, 32'h0);
		cy(SL + 20);
		starts = 0;
		wr(OFS_SW_TRIG, 32'h2);
		ckr(OFS_CROSS_BUSY, 32'h400);
		cy(SL + 20);
		chk("swtrig", starts, 1);
		wr(OFS_SEQ_EN, 32'h5);
		dly <= 4'hf;
		pq.delete();
		convTrigger <= 1'b1;
		cy(1);
		convTrigger <= 1'b0;
		cy(2);
		rd(OFS_SEQ_STATE, rv);
		chk("busy", rv[7], 1);
		cy(60);
		ckr(OFS_SEQ_STATE, 32'h2);
		chk("seqn", pq.size(), 2);
		chk("seq0", pq[0], 0);
		chk("seq1", pq[1], 2);
		endSim();
	end
endmodule
`default_nettype wire
